// ---- jfl_defs.svh ----
// constants of the serial-test-port flash storage block
`ifndef JFL_DEFS_SVH
`define JFL_DEFS_SVH

// ----------------------------------------
// array geometry
// ----------------------------------------
`define JFL_MEM_BYTES 2048
`define JFL_ADDR_ONE 11'h001
`define JFL_PAGE_LAST 5'h1F
`define JFL_PAGE_ZERO 5'h00
`define JFL_BLK0_BASE 11'h000
`define JFL_BLK1_BASE 11'h080
`define JFL_BLK2_BASE 11'h200
`define JFL_BLK3_BASE 11'h400
`define JFL_BLK0_LAST 11'h07F
`define JFL_BLK1_LAST 11'h1FF
`define JFL_BLK2_LAST 11'h3FF
`define JFL_BLK3_LAST 11'h7FF
`define JFL_ERASED 8'hFF

// ----------------------------------------
// command bytes
// ----------------------------------------
`define JFL_KEY1 8'hAA
`define JFL_KEY2 8'h55
`define JFL_OP_PROG 4'hA
`define JFL_OP_ERASE 4'h8
`define JFL_OP_LOCK 4'hC

// ----------------------------------------
// test port
// ----------------------------------------
`define JFL_IR_CAPTURE 4'h1
`define JFL_IDCODE 32'h0000_0001
`define JFL_DR_ZERO 32'h0000_0000

// ----------------------------------------
// timing
// ----------------------------------------
`define JFL_CLK_NS 8
`define JFL_PROG_NS 4000
`define JFL_ERASE_NS 8000
`define JFL_PROG_CYC ((`JFL_PROG_NS + `JFL_CLK_NS - 1) / `JFL_CLK_NS)
`define JFL_ERASE_CYC ((`JFL_ERASE_NS + `JFL_CLK_NS - 1) / `JFL_CLK_NS)
`define JFL_TMR_ZERO 16'h0000
`define JFL_TMR_ONE 16'h0001

`endif

// ---- jfl_pkg.sv ----
// types of the serial-test-port flash storage block
package jfl_pkg;

    // ----------------------------------------
    // test port controller states
    // ----------------------------------------
    typedef enum logic [3:0] {
        TAP_RESET = 4'hF, TAP_IDLE = 4'hC, TAP_SEL_DR = 4'h7, TAP_CAP_DR = 4'h6,
        TAP_SHIFT_DR = 4'h2, TAP_EXIT1_DR = 4'h1, TAP_PAUSE_DR = 4'h3,
        TAP_EXIT2_DR = 4'h0, TAP_UPD_DR = 4'h5, TAP_SEL_IR = 4'h4,
        TAP_CAP_IR = 4'hE, TAP_SHIFT_IR = 4'hA, TAP_EXIT1_IR = 4'h9,
        TAP_PAUSE_IR = 4'hB, TAP_EXIT2_IR = 4'h8, TAP_UPD_IR = 4'hD
    } jfl_tap_state_type;

    typedef enum logic [3:0] {
        IR_IDCODE = 4'h1, IR_ADDR = 4'h2, IR_READ = 4'h3, IR_PAGE = 4'h4,
        IR_CMD = 4'h5, IR_STATUS = 4'h6, IR_BYPASS = 4'hF
    } jfl_ir_type;

    typedef enum logic [1:0] {
        OP_IDLE = 2'b00, OP_PROG = 2'b01, OP_WAIT = 2'b11, OP_ERASE = 2'b10
    } jfl_op_state_type;

    typedef struct packed {
        logic busy;
        logic done;
        logic reject;
        logic test_mode;
        logic [3:0] locks;
    } jfl_status_type;

endpackage

// ---- jfl_flash_tap.sv ----
// flash storage with per-block lock bits behind a serial test port
//
// Overview of operation
// - four blocks of 128, 384, 512 and 1024 bytes
// - each block erases alone, others untouched
// - one write-once lock bit per block blocks erase and program
// - program and erase ignored while supply is not good
// - commands run only after the two-byte unlock sequence
// - controller state follows mode-select at rising test clock
// - controller state changes only on a test clock edge
// - serial input captured on rising test clock
// - serial output changes only on falling test clock
// - first override low: lock bit 0 decides for block 0
// - first override high: block 0 always writable
// - first override at high voltage enters manufacturing test mode
// - second override low: own lock bits decide blocks 1 to 3
// - second override high: blocks 1 to 3 always writable
// - erased bits read one, programming only clears bits
// - one program writes 1 to 32 bytes in one page
// - instruction register selects data, bypass and identity registers
// - self-timed operations, status pollable while busy
`timescale 1ns/1ps
`include "jfl_defs.svh"

module jfl_flash_tap
    import jfl_pkg::*;
(
    input wire logic mclk_in,
    input wire logic reset_n_in,
    input wire logic tck_in,
    input wire logic tms_in,
    input wire logic tdi_in,
    output logic tdo_out,
    output logic tdo_oe_out,
    input wire logic lock_override_low_block_in,
    input wire logic lock_override_upper_blocks_in,
    input wire logic lock_override_hv_in,
    input wire logic supply_good_in,
    output jfl_status_type status_out
);

    // ----------------------------------------
    // test clock edges
    // ----------------------------------------
    logic tck_q;
    logic tck_rise;
    logic tck_fall;

    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            tck_q <= 1'b1; // parked-high level, so release makes no false rise
        end else begin
            tck_q <= tck_in;
        end
    end
    assign tck_rise = tck_in & ~tck_q;
    assign tck_fall = ~tck_in & tck_q;

    // ----------------------------------------
    // controller state machine
    // ----------------------------------------
    jfl_tap_state_type tap_st;
    jfl_tap_state_type next_tap_st;

    always_comb begin
        case (tap_st)
            TAP_RESET: next_tap_st = tms_in ? TAP_RESET : TAP_IDLE;
            TAP_IDLE: next_tap_st = tms_in ? TAP_SEL_DR : TAP_IDLE;
            TAP_SEL_DR: next_tap_st = tms_in ? TAP_SEL_IR : TAP_CAP_DR;
            TAP_CAP_DR: next_tap_st = tms_in ? TAP_EXIT1_DR : TAP_SHIFT_DR;
            TAP_SHIFT_DR: next_tap_st = tms_in ? TAP_EXIT1_DR : TAP_SHIFT_DR;
            TAP_EXIT1_DR: next_tap_st = tms_in ? TAP_UPD_DR : TAP_PAUSE_DR;
            TAP_PAUSE_DR: next_tap_st = tms_in ? TAP_EXIT2_DR : TAP_PAUSE_DR;
            TAP_EXIT2_DR: next_tap_st = tms_in ? TAP_UPD_DR : TAP_SHIFT_DR;
            TAP_UPD_DR: next_tap_st = tms_in ? TAP_SEL_DR : TAP_IDLE;
            TAP_SEL_IR: next_tap_st = tms_in ? TAP_RESET : TAP_CAP_IR;
            TAP_CAP_IR: next_tap_st = tms_in ? TAP_EXIT1_IR : TAP_SHIFT_IR;
            TAP_SHIFT_IR: next_tap_st = tms_in ? TAP_EXIT1_IR : TAP_SHIFT_IR;
            TAP_EXIT1_IR: next_tap_st = tms_in ? TAP_UPD_IR : TAP_PAUSE_IR;
            TAP_PAUSE_IR: next_tap_st = tms_in ? TAP_EXIT2_IR : TAP_PAUSE_IR;
            TAP_EXIT2_IR: next_tap_st = tms_in ? TAP_UPD_IR : TAP_SHIFT_IR;
            TAP_UPD_IR: next_tap_st = tms_in ? TAP_SEL_DR : TAP_IDLE;
            default: next_tap_st = TAP_RESET;
        endcase
    end

    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            tap_st <= TAP_RESET;
        end else if (tck_rise) begin
            tap_st <= next_tap_st;
        end
    end

    // ----------------------------------------
    // instruction and data scan paths
    // ----------------------------------------
    jfl_ir_type ir;
    logic [3:0] ir_sh;
    logic [31:0] dr_sh;
    logic dr_upd;
    logic [7:0] upd_byte;
    logic [10:0] addr;
    logic [7:0] mem [0:`JFL_MEM_BYTES-1];
    jfl_status_type stat;

    assign dr_upd = tck_rise && tap_st == TAP_UPD_DR;
    assign upd_byte = dr_sh[31:24];

    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            ir_sh <= `JFL_IR_CAPTURE;
            ir <= IR_IDCODE;
        end else if (tck_rise) begin
            if (tap_st == TAP_RESET) begin
                ir <= IR_IDCODE;
            end else if (tap_st == TAP_CAP_IR) begin
                ir_sh <= `JFL_IR_CAPTURE;
            end else if (tap_st == TAP_SHIFT_IR) begin
                ir_sh <= {tdi_in, ir_sh[3:1]};
            end else if (tap_st == TAP_UPD_IR) begin
                case (ir_sh)
                    IR_IDCODE, IR_ADDR, IR_READ, IR_PAGE, IR_CMD, IR_STATUS: ir <= jfl_ir_type'(ir_sh);
                    default: ir <= IR_BYPASS;
                endcase
            end
        end
    end

    // captured value sits at the low end, shifted bits arrive at the top
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            dr_sh <= `JFL_DR_ZERO;
        end else if (tck_rise && tap_st == TAP_CAP_DR) begin
            case (ir)
                IR_IDCODE: dr_sh <= `JFL_IDCODE;
                IR_ADDR: dr_sh <= {21'h0, addr};
                IR_READ: dr_sh <= {24'h0, mem[addr]};
                IR_STATUS: dr_sh <= {24'h0, stat};
                default: dr_sh <= `JFL_DR_ZERO;
            endcase
        end else if (tck_rise && tap_st == TAP_SHIFT_DR && ir == IR_BYPASS) begin
            // bypass is a single stage between tdi and tdo
            dr_sh <= {31'h0000_0000, tdi_in};
        end else if (tck_rise && tap_st == TAP_SHIFT_DR) begin
            dr_sh <= {tdi_in, dr_sh[31:1]};
        end
    end

    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            tdo_out <= 1'b0;
            tdo_oe_out <= 1'b0;
        end else if (tck_fall) begin
            tdo_out <= (tap_st == TAP_SHIFT_IR) ? ir_sh[0] : dr_sh[0];
            tdo_oe_out <= tap_st == TAP_SHIFT_IR || tap_st == TAP_SHIFT_DR;
        end
    end

    // ----------------------------------------
    // blocks, locks and permission
    // ----------------------------------------
    logic [3:0] lock_bits;
    logic [3:0] blk_ok;
    jfl_op_state_type op_st;
    logic [10:0] cursor;
    logic [15:0] tmr;
    logic [1:0] op_blk;
    logic op_lock;
    logic [7:0] pbuf [0:31];
    logic [31:0] pvalid;

    function automatic logic [1:0] blk_of(input logic [10:0] a);
        if (a >= `JFL_BLK3_BASE) begin
            blk_of = 2'd3;
        end else if (a >= `JFL_BLK2_BASE) begin
            blk_of = 2'd2;
        end else if (a >= `JFL_BLK1_BASE) begin
            blk_of = 2'd1;
        end else begin
            blk_of = 2'd0;
        end
    endfunction

    function automatic logic [10:0] blk_base(input logic [1:0] b);
        case (b)
            2'd0: blk_base = `JFL_BLK0_BASE;
            2'd1: blk_base = `JFL_BLK1_BASE;
            2'd2: blk_base = `JFL_BLK2_BASE;
            default: blk_base = `JFL_BLK3_BASE;
        endcase
    endfunction

    function automatic logic [10:0] blk_last(input logic [1:0] b);
        case (b)
            2'd0: blk_last = `JFL_BLK0_LAST;
            2'd1: blk_last = `JFL_BLK1_LAST;
            2'd2: blk_last = `JFL_BLK2_LAST;
            default: blk_last = `JFL_BLK3_LAST;
        endcase
    endfunction

    // override pins are levels; block 0 has its own, blocks 1 to 3 share one
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_perm
            if (g == 0) begin : g_low
                assign blk_ok[g] = ~lock_bits[g] | lock_override_low_block_in;
            end else begin : g_up
                assign blk_ok[g] = ~lock_bits[g] | lock_override_upper_blocks_in;
            end
        end
    endgenerate

    // ----------------------------------------
    // unlock sequence and command decode
    // ----------------------------------------
    logic [1:0] seq;
    logic cmd_upd;
    logic cmd_exec;
    logic accept;
    logic [3:0] cmd_kind;
    logic [1:0] cmd_blk;
    logic cmd_ok;

    assign cmd_upd = dr_upd && ir == IR_CMD;
    assign cmd_kind = upd_byte[7:4];
    assign cmd_blk = upd_byte[1:0];
    // hv test mode replaces normal operation, so nothing runs there
    assign cmd_ok = supply_good_in && !stat.test_mode && op_st == OP_IDLE;
    assign cmd_exec = cmd_upd && seq == 2'd2 && cmd_ok;

    always_comb begin
        case (cmd_kind)
            `JFL_OP_PROG: accept = blk_ok[blk_of(addr)] && |pvalid;
            `JFL_OP_ERASE: accept = blk_ok[cmd_blk];
            `JFL_OP_LOCK: accept = 1'b1;
            default: accept = 1'b0;
        endcase
    end

    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            seq <= 2'd0;
        end else if (!supply_good_in) begin
            seq <= 2'd0;
        end else if (cmd_upd) begin
            if (seq == 2'd0 && upd_byte == `JFL_KEY1) begin
                seq <= 2'd1;
            end else if (seq == 2'd1 && upd_byte == `JFL_KEY2) begin
                seq <= 2'd2;
            end else begin
                seq <= 2'd0;
            end
        end
    end

    // ----------------------------------------
    // address and page buffer
    // ----------------------------------------
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            addr <= `JFL_BLK0_BASE;
        end else if (dr_upd && ir == IR_ADDR) begin
            addr <= dr_sh[31:21];
        end else if (dr_upd && ir == IR_READ) begin
            addr <= addr + `JFL_ADDR_ONE;
        end else if (dr_upd && ir == IR_PAGE && op_st == OP_IDLE) begin
            addr[4:0] <= addr[4:0] + 5'h01;
        end
    end

    // loading is refused while busy: the engine is reading the buffer
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            pvalid <= 32'h0000_0000;
        end else if (op_st == OP_PROG && cursor[4:0] == `JFL_PAGE_LAST) begin
            pvalid <= 32'h0000_0000;
        end else if (dr_upd && ir == IR_PAGE && op_st == OP_IDLE) begin
            pvalid[addr[4:0]] <= 1'b1;
        end
    end

    always_ff @(posedge mclk_in) begin
        if (dr_upd && ir == IR_PAGE && op_st == OP_IDLE) begin
            pbuf[addr[4:0]] <= upd_byte;
        end
    end

    // ----------------------------------------
    // self-timed program and erase engine
    // ----------------------------------------
    logic mem_we;
    logic [7:0] mem_wd;

    assign mem_we = op_st == OP_ERASE || (op_st == OP_PROG && pvalid[cursor[4:0]]);
    assign mem_wd = (op_st == OP_ERASE) ? `JFL_ERASED : (mem[cursor] & pbuf[cursor[4:0]]);

    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            op_st <= OP_IDLE;
            cursor <= `JFL_BLK0_BASE;
            tmr <= `JFL_TMR_ZERO;
            op_blk <= 2'd0;
            op_lock <= 1'b0;
        end else begin
            case (op_st)
                OP_IDLE: begin
                    if (cmd_exec && accept) begin
                        op_lock <= cmd_kind == `JFL_OP_LOCK;
                        if (cmd_kind == `JFL_OP_PROG) begin
                            op_st <= OP_PROG;
                            cursor <= {addr[10:5], `JFL_PAGE_ZERO};
                            op_blk <= blk_of(addr);
                        end else if (cmd_kind == `JFL_OP_ERASE) begin
                            op_st <= OP_ERASE;
                            cursor <= blk_base(cmd_blk);
                            op_blk <= cmd_blk;
                        end else begin
                            op_st <= OP_WAIT;
                            tmr <= 16'(`JFL_PROG_CYC);
                            op_blk <= cmd_blk;
                        end
                    end
                end
                OP_PROG: begin
                    cursor <= cursor + `JFL_ADDR_ONE;
                    if (cursor[4:0] == `JFL_PAGE_LAST) begin
                        op_st <= OP_WAIT;
                        tmr <= 16'(`JFL_PROG_CYC);
                    end
                end
                OP_ERASE: begin
                    if (cursor == blk_last(op_blk)) begin
                        op_st <= OP_WAIT;
                        tmr <= 16'(`JFL_ERASE_CYC);
                    end else begin
                        cursor <= cursor + `JFL_ADDR_ONE;
                    end
                end
                OP_WAIT: begin
                    if (tmr == `JFL_TMR_ZERO) begin
                        op_st <= OP_IDLE;
                    end else begin
                        tmr <= tmr - `JFL_TMR_ONE;
                    end
                end
                default: op_st <= OP_IDLE;
            endcase
        end
    end

    always_ff @(posedge mclk_in) begin
        if (mem_we) begin
            mem[cursor] <= mem_wd;
        end
    end

    // lock bits only ever set; erase has no path to them
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            lock_bits <= 4'h0;
        end else if (op_st == OP_WAIT && tmr == `JFL_TMR_ZERO && op_lock) begin
            lock_bits[op_blk] <= 1'b1;
        end
    end

    // ----------------------------------------
    // status, read by the status instruction
    // ----------------------------------------
    logic stat_read;
    assign stat_read = tck_rise && tap_st == TAP_CAP_DR && ir == IR_STATUS;

    logic done_flag;
    logic reject_flag;
    logic test_mode_flag;

    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            done_flag <= 1'b0;
            reject_flag <= 1'b0;
            test_mode_flag <= 1'b0;
        end else begin
            test_mode_flag <= lock_override_hv_in;
            // a new event wins over the clear done by reading status
            if (op_st == OP_WAIT && tmr == `JFL_TMR_ZERO) begin
                done_flag <= 1'b1;
            end else if (stat_read) begin
                done_flag <= 1'b0;
            end
            if (cmd_upd && (seq == 2'd2) && !(cmd_ok && accept)) begin
                reject_flag <= 1'b1;
            end else if (stat_read) begin
                reject_flag <= 1'b0;
            end
        end
    end
    assign stat = '{busy: op_st != OP_IDLE, done: done_flag, reject: reject_flag,
                    test_mode: test_mode_flag, locks: lock_bits};
    assign status_out = stat;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!reset_n_in);

    AST_TDO_FALL: assert property (!tck_fall |=> $stable(tdo_out))
        else $error("serial output moved without falling test clock");
    AST_TAP_SYNC: assert property (!tck_rise |=> $stable(tap_st))
        else $error("controller state moved without rising test clock");
    AST_TAP_TMS: assert property (tck_rise && tap_st == TAP_IDLE |=> tap_st == (tms_in ? TAP_SEL_DR : TAP_IDLE))
        else $error("controller did not follow mode select");
    AST_SUPPLY: assert property (!supply_good_in && op_st == OP_IDLE |=> op_st == OP_IDLE)
        else $error("operation started with supply not good");
    AST_SEQ: assert property (op_st == OP_IDLE && !(cmd_upd && seq == 2'd2) |=> op_st == OP_IDLE)
        else $error("operation started without unlock sequence");
    AST_LOCK_GUARD: assert property (mem_we |-> blk_ok[blk_of(cursor)])
        else $error("write into a locked block");
    AST_OVERRIDE: assert property (cmd_exec && cmd_kind == `JFL_OP_ERASE && ((cmd_blk == 2'd0) ? lock_override_low_block_in : lock_override_upper_blocks_in) |=> op_st == OP_ERASE)
        else $error("override did not admit erase");
    AST_ERASE_ONES: assert property (op_st == OP_ERASE |-> mem_wd == `JFL_ERASED && blk_of(cursor) == op_blk)
        else $error("erase wrote outside its block or not all ones");
    AST_PROG_CLEAR: assert property (op_st == OP_PROG && mem_we |-> (mem_wd & ~mem[cursor]) == 8'h00)
        else $error("programming set a bit");
    AST_PAGE: assert property (op_st == OP_PROG |=> op_st == OP_WAIT || cursor[10:5] == $past(cursor[10:5]))
        else $error("program left its page");
    AST_LOCK_KEEP: assert property (1'b1 |=> (~lock_bits & $past(lock_bits)) == 4'h0)
        else $error("a lock bit was cleared");

endmodule // jfl_flash_tap

// ---- jfl_scan_master.sv ----
// scan bus master model driving the serial test port
`timescale 1ns/1ps

module jfl_scan_master (
    input wire logic mclk_in,
    input wire logic tdo_in,
    output logic tck_out,
    output logic tms_out,
    output logic tdi_out
);
    // ----------------------------------------
    // bus cycle
    // ----------------------------------------
    // tck parks high between frames; low 3, high 2 mclk keeps both phases >= 2 samples
    initial begin
        tck_out = 1'b1;
        tms_out = 1'b1;
        tdi_out = 1'b0;
    end

    task automatic tick(input logic m, input logic d, output logic q);
        tck_out <= 1'b0;
        tms_out <= m;
        tdi_out <= d;
        repeat (3) @(posedge mclk_in);
        q = tdo_in;
        tck_out <= 1'b1;
        repeat (2) @(posedge mclk_in);
    endtask

    task automatic tap_reset();
        logic q;
        repeat (5) tick(1'b1, 1'b0, q);
        tick(1'b0, 1'b0, q);
    endtask

    // one ir or dr scan from idle back to idle, lsb first
    task automatic scan(input logic ir, input int n, input logic [31:0] din, output logic [31:0] dout);
        logic q;
        int i;
        dout = 32'h0000_0000;
        tick(1'b1, 1'b0, q);
        if (ir) tick(1'b1, 1'b0, q);
        tick(1'b0, 1'b0, q);
        tick(1'b0, 1'b0, q);
        for (i = 0; i < n; i++) begin
            tick(i == n - 1, din[i], q);
            dout[i] = q;
        end
        tick(1'b1, 1'b0, q);
        tick(1'b0, 1'b0, q);
    endtask
endmodule // jfl_scan_master

// ---- tb_top.sv ----
// self-checking bench for the flash storage test port block
`timescale 1ns/1ps
`include "jfl_defs.svh"

module tb_top
    import jfl_pkg::*;
;
    logic mclk, reset_n, tck, tms, tdi, tdo, tdo_oe, q, lock_override_low_block, lock_override_upper_blocks, hv, supply;
    jfl_status_type status;
    logic [31:0] sout;
    int fails = 0, checks_done = 0, cyc = 0, i;

    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end

    jfl_flash_tap uut (.mclk_in(mclk), .reset_n_in(reset_n), .tck_in(tck), .tms_in(tms), .tdi_in(tdi),
        .tdo_out(tdo), .tdo_oe_out(tdo_oe), .lock_override_low_block_in(lock_override_low_block), .lock_override_upper_blocks_in(lock_override_upper_blocks),
        .lock_override_hv_in(hv), .supply_good_in(supply), .status_out(status));
    jfl_scan_master u_master (.mclk_in(mclk), .tdo_in(tdo), .tck_out(tck), .tms_out(tms), .tdi_out(tdi));

    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic final_report();
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic sc(input logic ir, input int n, input logic [31:0] din);
        u_master.scan(ir, n, din, sout);
    endtask

    task automatic ir(input jfl_ir_type x);
        sc(1'b1, 4, {28'h0, x});
    endtask

    task automatic set_addr(input logic [10:0] a);
        ir(IR_ADDR);
        sc(1'b0, 11, {21'h0, a});
    endtask

    task automatic wr(input logic [10:0] a, input logic [7:0] d);
        set_addr(a);
        ir(IR_PAGE);
        sc(1'b0, 8, {24'h0, d});
    endtask

    task automatic rd(input logic [10:0] a, input logic [7:0] exp);
        set_addr(a);
        ir(IR_READ);
        sc(1'b0, 8, 32'h0);
        check(sout & 32'hFF, {24'h0, exp});
    endtask

    // waits out busy under a bound; erase of the big block is the longest
    task automatic cmd3(input logic [7:0] k1, input logic [7:0] k2, input logic [7:0] c);
        int k;
        ir(IR_CMD);
        sc(1'b0, 8, {24'h0, k1});
        sc(1'b0, 8, {24'h0, k2});
        sc(1'b0, 8, {24'h0, c});
        k = 0;
        while (status.busy === 1'b1 && k < 3000) begin
            @(posedge mclk);
            k++;
        end
        check({31'h0, status.busy}, 32'h0);
    endtask

    task automatic cmd(input logic [7:0] c);
        cmd3(`JFL_KEY1, `JFL_KEY2, c);
    endtask

    // ----------------------------------------
    // sequence
    // ----------------------------------------
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 50000) begin
            fails++;
            final_report();
        end
    end

    initial begin
        reset_n = 1'b0;
        lock_override_low_block = 1'b0;
        lock_override_upper_blocks = 1'b0;
        hv = 1'b0;
        supply = 1'b1;
        repeat (2) @(posedge mclk);
        reset_n <= 1'b1;
        @(posedge mclk);
        u_master.tap_reset();
        sc(1'b1, 4, {28'h0, IR_IDCODE});
        check(sout & 32'hF, {28'h0, `JFL_IR_CAPTURE});
        sc(1'b0, 32, 32'h0);
        check(sout, `JFL_IDCODE);
        ir(IR_BYPASS);
        sc(1'b0, 2, 32'h1);
        check(sout & 32'h3, 32'h2);
        u_master.tick(1'b1, 1'b0, q);
        u_master.tick(1'b0, 1'b0, q);
        u_master.tick(1'b0, 1'b0, q);
        u_master.tick(1'b0, 1'b1, q);
        check({31'h0, tdo_oe}, 32'h1);
        u_master.tick(1'b1, 1'b0, q);
        check({31'h0, q}, 32'h1);
        u_master.tick(1'b1, 1'b0, q);
        u_master.tick(1'b0, 1'b0, q);
        check({31'h0, tdo_oe}, 32'h0);
        for (i = 0; i < 4; i++) cmd({`JFL_OP_ERASE, 2'b00, i[1:0]});
        rd(`JFL_BLK0_BASE, `JFL_ERASED);
        rd(`JFL_BLK3_LAST, `JFL_ERASED);
        wr(`JFL_BLK0_LAST, 8'h5A);
        cmd({`JFL_OP_PROG, 4'h0});
        wr(`JFL_BLK0_LAST, 8'hF0);
        cmd({`JFL_OP_PROG, 4'h0});
        rd(`JFL_BLK0_LAST, 8'h50);
        wr(`JFL_BLK1_BASE, 8'h3C);
        cmd({`JFL_OP_PROG, 4'h0});
        set_addr(`JFL_BLK2_BASE);
        ir(IR_PAGE);
        for (i = 0; i < 32; i++) sc(1'b0, 8, {24'h0, i[7:0] ^ 8'hC3});
        cmd({`JFL_OP_PROG, 4'h0});
        set_addr(`JFL_BLK2_BASE);
        check(sout & 32'h7FF, {21'h0, `JFL_BLK2_BASE});
        ir(IR_READ);
        for (i = 0; i < 32; i++) begin
            sc(1'b0, 8, 32'h0);
            check(sout & 32'hFF, {24'h0, i[7:0] ^ 8'hC3});
        end
        cmd({`JFL_OP_ERASE, 4'h0});
        rd(`JFL_BLK0_LAST, `JFL_ERASED);
        rd(`JFL_BLK1_BASE, 8'h3C);
        cmd3(`JFL_KEY1, 8'h12, {`JFL_OP_ERASE, 4'h1});
        rd(`JFL_BLK1_BASE, 8'h3C);
        supply <= 1'b0;
        cmd({`JFL_OP_ERASE, 4'h1});
        supply <= 1'b1;
        rd(`JFL_BLK1_BASE, 8'h3C);
        cmd({`JFL_OP_LOCK, 4'h1});
        check({28'h0, status.locks}, 32'h2);
        cmd({`JFL_OP_ERASE, 4'h1});
        check({31'h0, status.reject}, 32'h1);
        rd(`JFL_BLK1_BASE, 8'h3C);
        ir(IR_STATUS);
        sc(1'b0, 8, 32'h0);
        check(sout & 32'hFF, 32'h62);
        check({30'h0, status.done, status.reject}, 32'h0);
        lock_override_upper_blocks <= 1'b1;
        cmd({`JFL_OP_ERASE, 4'h1});
        rd(`JFL_BLK1_BASE, `JFL_ERASED);
        check({28'h0, status.locks}, 32'h2);
        cmd({`JFL_OP_LOCK, 4'h0});
        wr(`JFL_BLK0_BASE, 8'h00);
        cmd({`JFL_OP_PROG, 4'h0});
        rd(`JFL_BLK0_BASE, `JFL_ERASED);
        lock_override_low_block <= 1'b1;
        wr(`JFL_BLK0_BASE, 8'h00);
        cmd({`JFL_OP_PROG, 4'h0});
        rd(`JFL_BLK0_BASE, 8'h00);
        hv <= 1'b1;
        repeat (3) @(posedge mclk);
        check({31'h0, status.test_mode}, 32'h1);
        final_report();
    end
endmodule // tb_top
